// file: rtl/cise_pkg.sv
/*
  Shared constants and types of the instruction subset executor: register
  offsets, field positions, reset values, opcode encoding, execution states.
  Assumes a 32-bit APB with byte addresses on an 8-bit address bus.
*/
package cise_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_WREG = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_PCLATCH = 8'h10;
  localparam logic [7:0] OFS_FADDR = 8'h14;
  localparam logic [7:0] OFS_FDATA = 8'h18;
  localparam logic [7:0] OFS_TOS = 8'h1c;
  localparam logic [7:0] OFS_STKPTR = 8'h20;
  localparam logic [7:0] OFS_WATCHDOG = 8'h24;
  localparam logic [7:0] OFS_CYCLES = 8'h28;

  // Instruction word fields
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 12;
  localparam int DEST_BIT = 11;
  localparam int IMM_MSB = 10;
  localparam int FADDR_MSB = 6;

  // Status field positions
  localparam int ST_ZERO_BIT = 0;
  localparam int ST_PD_BIT = 1;
  localparam int ST_TO_BIT = 2;

  // Sizes
  localparam int FILE_DEPTH = 128;
  localparam int STACK_DEPTH = 8;

  // Reset values
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic RST_ZERO = 1'b0;
  localparam logic RST_PD = 1'b1;
  localparam logic RST_TO = 1'b1;
  localparam logic [12:0] RST_PC = 13'h0000;
  localparam logic [4:0] RST_PCLATCH = 5'h00;
  localparam logic [7:0] RST_FILE = 8'h00;
  localparam logic [12:0] RST_STACK = 13'h0000;

  // Watchdog prescaler wrap value; the counter advances once per wrap
  localparam logic [7:0] PRESCALE_WRAP = 8'hff;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_CLEAR_WATCHDOG = 4'h1,
    OP_CALL = 4'h2,
    OP_COMPLEMENT_FILE = 4'h3,
    OP_CLEAR_FILE = 4'h4,
    OP_CLEAR_WORKING = 4'h5,
    OP_DECREMENT_FILE = 4'h6,
    OP_DECREMENT_SKIP_ZERO = 4'h7
  } cise_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SECOND = 2'b10
  } cise_state_t;

endpackage

// file: rtl/cise_core_if.sv
/*
  Bundle between the executor and its file bank and return stack.
  Assumes all three parts run on the same clock.
*/
`timescale 1ns/1ps
interface cise_core_if;
  logic [6:0] f_raddr;
  logic [7:0] f_rdata;
  logic f_we;
  logic [6:0] f_waddr;
  logic [7:0] f_wdata;
  logic s_push;
  logic [12:0] s_data;
  logic [12:0] s_top;
  logic [2:0] s_ptr;

  modport core (
    output f_raddr, f_we, f_waddr, f_wdata, s_push, s_data,
    input f_rdata, s_top, s_ptr
  );
  modport bank (
    input f_raddr, f_we, f_waddr, f_wdata,
    output f_rdata
  );
  modport stack (
    input s_push, s_data,
    output s_top, s_ptr
  );
endinterface

// file: rtl/cise_file_bank.sv
/*
  File register storage, 128 bytes of flip-flops, one write and one read port.
  Assumes writes come only from the executor, one per cycle.
*/
`timescale 1ns/1ps
module cise_file_bank (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Executor side
  cise_core_if.bank bus
);
  typedef struct packed {
    logic [cise_pkg::FILE_DEPTH-1:0][7:0] mem;
  } cise_bank_t;

  cise_bank_t r;
  cise_bank_t next_r;

  // Read is combinational so an instruction reads and writes in one cycle
  assign bus.f_rdata = r.mem[bus.f_raddr];

  always_comb
  begin
    next_r = r;
    if (bus.f_we)
    begin
      next_r.mem[bus.f_waddr] = bus.f_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= {cise_pkg::FILE_DEPTH{cise_pkg::RST_FILE}};
    end
    else
    begin
      r <= next_r;
    end
  end
endmodule

// file: rtl/cise_return_stack.sv
/*
  Hardware return stack of 13-bit addresses, eight entries, circular.
  Assumes pushes only; a ninth push silently overwrites the oldest entry.
*/
`timescale 1ns/1ps
module cise_return_stack (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Executor side
  cise_core_if.stack bus
);
  typedef struct packed {
    logic [cise_pkg::STACK_DEPTH-1:0][12:0] ent;
    logic [2:0] ptr;
  } cise_stack_t;

  cise_stack_t r;
  cise_stack_t next_r;

  assign bus.s_top = r.ent[r.ptr - 3'h1];
  assign bus.s_ptr = r.ptr;

  always_comb
  begin
    next_r = r;
    if (bus.s_push)
    begin
      next_r.ent[r.ptr] = bus.s_data;
      next_r.ptr = r.ptr + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= {{cise_pkg::STACK_DEPTH{cise_pkg::RST_STACK}}, 3'h0};
    end
    else
    begin
      r <= next_r;
    end
  end
endmodule

// file: rtl/cise_exec.sv
/*
  Executor for a subset of an 8-bit core's instructions, with an APB slave
  for issue and inspection. One pclk cycle is one instruction cycle.
  Assumes an APB master on pclk; file bank and return stack are instantiated.
*/
// Operation
// - Clearing the watchdog zeroes its counter and its prescaler, with no operands.
// - Clearing the watchdog sets the timeout and powerdown flags and no other status bit.
// - A call first pushes the current program counter plus one onto the return stack.
// - A call loads PC bits 10..0 from its immediate and PC bits 12..11 from latch bits 4..3.
// - A call takes two instruction cycles and leaves the status flags alone.
// - Complement inverts the addressed file register's value, routes it and updates the zero flag.
// - A destination bit of 0 sends the result to the working register, 1 to the file.
// - Clear-file zeroes the addressed file register and always sets the zero flag.
// - Clear-working zeroes the working register and always sets the zero flag.
// - Decrement subtracts one from the file register, routes it and updates the zero flag.
// - Decrement-and-skip subtracts one, routes it and leaves all status flags alone.
// - A zero result of decrement-and-skip turns the next instruction into a no-operation.
`timescale 1ns/1ps
module cise_exec (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    cise_pkg::cise_state_t st;
    logic [15:0] instr;
    logic [7:0] wreg;
    logic zero_flag;
    logic powerdown_flag;
    logic timeout_flag;
    logic [12:0] pc;
    logic [4:0] pc_high_latch;
    logic [6:0] faddr;
    logic [7:0] prescaler;
    logic [7:0] watchdog_counter;
    logic [31:0] cycles;
    logic skip;
  } cise_exec_t;

  localparam cise_exec_t RST = '{
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    st: cise_pkg::ST_IDLE,
    instr: cise_pkg::RST_INSTR,
    wreg: cise_pkg::RST_WREG,
    zero_flag: cise_pkg::RST_ZERO,
    powerdown_flag: cise_pkg::RST_PD,
    timeout_flag: cise_pkg::RST_TO,
    pc: cise_pkg::RST_PC,
    pc_high_latch: cise_pkg::RST_PCLATCH,
    faddr: 7'h00,
    prescaler: 8'h00,
    watchdog_counter: 8'h00,
    cycles: 32'h0000_0000,
    skip: 1'b0
  };

  cise_exec_t r;
  cise_exec_t next_r;

  cise_core_if core_bus ();

  cise_file_bank u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .bus(core_bus.bank)
  );

  cise_return_stack u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .bus(core_bus.stack)
  );

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;

  always_comb
  begin
    logic [7:0] res;
    logic route;
    logic dest;
    logic [6:0] faddr_op;
    cise_pkg::cise_op_t op;
    logic take;
    logic commit;
    logic mapped;

    res = 8'h00;
    route = 1'b0;
    dest = r.instr[cise_pkg::DEST_BIT];
    faddr_op = r.instr[cise_pkg::FADDR_MSB:0];
    op = cise_pkg::cise_op_t'(r.instr[cise_pkg::OP_MSB:cise_pkg::OP_LSB]);
    take = psel && penable && !r.pready;
    commit = psel && penable && pwrite && r.pready;
    mapped = 1'b0;
    next_r = r;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    // Software sees the file through faddr except while an instruction runs
    core_bus.f_raddr = (r.st == cise_pkg::ST_EXEC) ? faddr_op : r.faddr;
    core_bus.f_we = 1'b0;
    core_bus.f_waddr = faddr_op;
    core_bus.f_wdata = 8'h00;
    core_bus.s_push = 1'b0;
    core_bus.s_data = r.pc + 13'h0001;

    // Free-running watchdog; an executed clear below overrides the count
    next_r.prescaler = r.prescaler + 8'h01;
    if (r.prescaler == cise_pkg::PRESCALE_WRAP)
    begin
      next_r.watchdog_counter = r.watchdog_counter + 8'h01;
    end

    // Word offsets of the map; any other address is refused with pslverr
    case (paddr)
      cise_pkg::OFS_INSTR, cise_pkg::OFS_WREG, cise_pkg::OFS_STATUS,
      cise_pkg::OFS_PC, cise_pkg::OFS_PCLATCH, cise_pkg::OFS_FADDR,
      cise_pkg::OFS_FDATA, cise_pkg::OFS_TOS, cise_pkg::OFS_STKPTR,
      cise_pkg::OFS_WATCHDOG, cise_pkg::OFS_CYCLES: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase

    unique case (r.st)
      cise_pkg::ST_IDLE:
      begin
        // Accesses wait in the access phase while an instruction is running
        if (take)
        begin
          next_r.pready = 1'b1;
          next_r.prdata = 32'h0000_0000;
          next_r.pslverr = !mapped;
          if (!pwrite)
          begin
            unique case (paddr)
              cise_pkg::OFS_INSTR: next_r.prdata = {16'h0000, r.instr};
              cise_pkg::OFS_WREG: next_r.prdata = {24'h000000, r.wreg};
              cise_pkg::OFS_STATUS:
              begin
                next_r.prdata[cise_pkg::ST_ZERO_BIT] = r.zero_flag;
                next_r.prdata[cise_pkg::ST_PD_BIT] = r.powerdown_flag;
                next_r.prdata[cise_pkg::ST_TO_BIT] = r.timeout_flag;
              end
              cise_pkg::OFS_PC: next_r.prdata = {19'h00000, r.pc};
              cise_pkg::OFS_PCLATCH: next_r.prdata = {27'h0000000, r.pc_high_latch};
              cise_pkg::OFS_FADDR: next_r.prdata = {25'h0000000, r.faddr};
              cise_pkg::OFS_FDATA: next_r.prdata = {24'h000000, core_bus.f_rdata};
              cise_pkg::OFS_TOS: next_r.prdata = {19'h00000, core_bus.s_top};
              cise_pkg::OFS_STKPTR: next_r.prdata = {29'h00000000, core_bus.s_ptr};
              cise_pkg::OFS_WATCHDOG:
                next_r.prdata = {16'h0000, r.prescaler, r.watchdog_counter};
              cise_pkg::OFS_CYCLES: next_r.prdata = r.cycles;
              default: ;
            endcase
          end
        end

        // Writes land at the edge that samples pready, while the master still holds them
        if (commit && mapped)
        begin
          unique case (paddr)
            cise_pkg::OFS_INSTR:
            begin
              next_r.instr = pwdata[15:0];
              next_r.st = cise_pkg::ST_EXEC;
            end
            cise_pkg::OFS_WREG: next_r.wreg = pwdata[7:0];
            cise_pkg::OFS_STATUS:
            begin
              next_r.zero_flag = pwdata[cise_pkg::ST_ZERO_BIT];
              next_r.powerdown_flag = pwdata[cise_pkg::ST_PD_BIT];
              next_r.timeout_flag = pwdata[cise_pkg::ST_TO_BIT];
            end
            cise_pkg::OFS_PC: next_r.pc = pwdata[12:0];
            cise_pkg::OFS_PCLATCH: next_r.pc_high_latch = pwdata[4:0];
            cise_pkg::OFS_FADDR: next_r.faddr = pwdata[6:0];
            cise_pkg::OFS_FDATA:
            begin
              core_bus.f_we = 1'b1;
              core_bus.f_waddr = r.faddr;
              core_bus.f_wdata = pwdata[7:0];
            end
            // Read-only words ignore writes without an error
            cise_pkg::OFS_TOS, cise_pkg::OFS_STKPTR,
            cise_pkg::OFS_WATCHDOG, cise_pkg::OFS_CYCLES: ;
            default: ;
          endcase
        end
      end

      cise_pkg::ST_EXEC:
      begin
        // One pass through this state is one instruction cycle
        next_r.st = cise_pkg::ST_IDLE;
        next_r.cycles = r.cycles + 32'h0000_0001;
        next_r.pc = r.pc + 13'h0001;
        if (r.skip)
        begin
          // Discarded instruction runs as a no-operation
          // A pending skip swallows the next issued word, a call included
          next_r.skip = 1'b0;
        end
        else
        begin
          unique case (op)
            cise_pkg::OP_NOP: ;
            cise_pkg::OP_CLEAR_WATCHDOG:
            begin
              next_r.watchdog_counter = 8'h00;
              next_r.prescaler = 8'h00;
              next_r.timeout_flag = 1'b1;
              next_r.powerdown_flag = 1'b1;
            end
            cise_pkg::OP_CALL:
            begin
              // s_data already holds PC plus one; the stack takes it at this edge
              core_bus.s_push = 1'b1;
              next_r.pc = {r.pc_high_latch[4:3], r.instr[cise_pkg::IMM_MSB:0]};
              next_r.st = cise_pkg::ST_SECOND;
            end
            cise_pkg::OP_COMPLEMENT_FILE:
            begin
              res = ~core_bus.f_rdata;
              route = 1'b1;
              next_r.zero_flag = (res == 8'h00);
            end
            cise_pkg::OP_CLEAR_FILE:
            begin
              core_bus.f_we = 1'b1;
              core_bus.f_wdata = 8'h00;
              next_r.zero_flag = 1'b1;
            end
            cise_pkg::OP_CLEAR_WORKING:
            begin
              next_r.wreg = 8'h00;
              next_r.zero_flag = 1'b1;
            end
            cise_pkg::OP_DECREMENT_FILE:
            begin
              res = core_bus.f_rdata - 8'h01;
              route = 1'b1;
              next_r.zero_flag = (res == 8'h00);
            end
            cise_pkg::OP_DECREMENT_SKIP_ZERO:
            begin
              // Status flags untouched here
              res = core_bus.f_rdata - 8'h01;
              route = 1'b1;
              next_r.skip = (res == 8'h00);
            end
            // Codes 8 to 15 run as a no-operation
            default: ;
          endcase
          if (route)
          begin
            if (dest)
            begin
              core_bus.f_we = 1'b1;
              core_bus.f_wdata = res;
            end
            else
            begin
              next_r.wreg = res;
            end
          end
        end
      end

      cise_pkg::ST_SECOND:
      begin
        // Second cycle of a call
        next_r.st = cise_pkg::ST_IDLE;
        next_r.cycles = r.cycles + 32'h0000_0001;
      end
      default: next_r.st = cise_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= RST;
    end
    else
    begin
      r <= next_r;
    end
  end
endmodule

// file: testbench/cise_exec_monitor.sv
/*
  Port checker for the executor's APB slave, bound into cise_exec.
  Assumes one clock, pclk, and the asynchronous active-low presetn.
*/
`timescale 1ns/1ps
module cise_exec_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_ready_cause: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without a taken access");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr outside an answer or with data");
  a_write_no_data: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write answer");
  a_unmapped_err: assert property (pready && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_answer_bound: assert property ($rose(psel && penable) |-> ##[1:6] pready)
    else $error("access not answered in time");
  a_status_narrow: assert property (pready && !pwrite && paddr == cise_pkg::OFS_STATUS
    |-> prdata[31:3] == 29'h0) else $error("status upper bits set");
  a_call_stall: assert property (pready && pwrite && paddr == cise_pkg::OFS_INSTR
    && pwdata[15:12] == cise_pkg::OP_CALL |=> !pready [*3])
    else $error("call answered the next access too soon");
  c_err: cover property (pslverr);
  c_call: cover property (pready && pwrite && paddr == cise_pkg::OFS_INSTR
    && pwdata[15:12] == cise_pkg::OP_CALL);
  c_instr: cover property (pready && pwrite && paddr == cise_pkg::OFS_INSTR);
  c_read: cover property (pready && !pwrite);
endmodule
bind cise_exec cise_exec_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// file: testbench/cise_exec_tb.sv
/*
  Self-checking bench: issues instructions and inspects state over APB.
  Assumes the register map and status layout of cise_pkg.
*/
`timescale 1ns/1ps
module cise_exec_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, c0;
  int failures, checks_done;
  cise_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Waits on pready, since instructions stretch the access phase
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 20)
      failures++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task rc(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task ex(input logic [3:0] op, input logic d, input logic [10:0] k);
    wr(cise_pkg::OFS_INSTR, {16'h0, op, d, k});
  endtask
  task setf(input logic [6:0] a, input logic [7:0] v);
    wr(cise_pkg::OFS_FADDR, {25'h0, a});
    wr(cise_pkg::OFS_FDATA, {24'h0, v});
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #2000000;
    failures++;
    print_verdict;
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    failures = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rc(cise_pkg::OFS_STATUS, 32'h6);
    rc(cise_pkg::OFS_STKPTR, 32'h0);
    rc(cise_pkg::OFS_TOS, 32'h0);
    $display("reset values done");
    setf(7'h7f, 8'h5a);
    ex(cise_pkg::OP_COMPLEMENT_FILE, 1'b0, 11'h07f);
    rc(cise_pkg::OFS_WREG, 32'ha5);
    rc(cise_pkg::OFS_FDATA, 32'h5a);
    rc(cise_pkg::OFS_STATUS, 32'h6);
    setf(7'h05, 8'hff);
    ex(cise_pkg::OP_COMPLEMENT_FILE, 1'b1, 11'h005);
    rc(cise_pkg::OFS_FDATA, 32'h0);
    rc(cise_pkg::OFS_STATUS, 32'h7);
    $display("complement done");
    setf(7'h09, 8'h33);
    wr(cise_pkg::OFS_STATUS, 32'h0);
    ex(cise_pkg::OP_CLEAR_FILE, 1'b0, 11'h009);
    rc(cise_pkg::OFS_FDATA, 32'h0);
    rc(cise_pkg::OFS_WREG, 32'ha5);
    rc(cise_pkg::OFS_STATUS, 32'h1);
    wr(cise_pkg::OFS_WREG, 32'h77);
    wr(cise_pkg::OFS_STATUS, 32'h0);
    ex(cise_pkg::OP_CLEAR_WORKING, 1'b0, 11'h0);
    rc(cise_pkg::OFS_WREG, 32'h0);
    rc(cise_pkg::OFS_STATUS, 32'h1);
    $display("clear done");
    setf(7'h09, 8'h01);
    ex(cise_pkg::OP_DECREMENT_FILE, 1'b1, 11'h009);
    rc(cise_pkg::OFS_FDATA, 32'h0);
    rc(cise_pkg::OFS_STATUS, 32'h1);
    ex(cise_pkg::OP_DECREMENT_FILE, 1'b0, 11'h009);
    rc(cise_pkg::OFS_WREG, 32'hff);
    rc(cise_pkg::OFS_STATUS, 32'h0);
    $display("decrement done");
    setf(7'h0a, 8'h01);
    wr(cise_pkg::OFS_WREG, 32'h77);
    wr(cise_pkg::OFS_STATUS, 32'h4);
    wr(cise_pkg::OFS_PC, 32'h10);
    xfer(1'b0, cise_pkg::OFS_CYCLES, 32'h0);
    c0 = r;
    ex(cise_pkg::OP_DECREMENT_SKIP_ZERO, 1'b1, 11'h00a);
    ex(cise_pkg::OP_CLEAR_WORKING, 1'b0, 11'h0);
    rc(cise_pkg::OFS_FDATA, 32'h0);
    rc(cise_pkg::OFS_WREG, 32'h77);
    rc(cise_pkg::OFS_STATUS, 32'h4);
    rc(cise_pkg::OFS_PC, 32'h12);
    rc(cise_pkg::OFS_CYCLES, c0 + 32'h2);
    setf(7'h0a, 8'h05);
    ex(cise_pkg::OP_DECREMENT_SKIP_ZERO, 1'b0, 11'h00a);
    rc(cise_pkg::OFS_WREG, 32'h4);
    rc(cise_pkg::OFS_FADDR, 32'h0a);
    ex(cise_pkg::OP_CLEAR_WORKING, 1'b0, 11'h0);
    rc(cise_pkg::OFS_STATUS, 32'h5);
    $display("skip done");
    wr(cise_pkg::OFS_PC, 32'h0123);
    wr(cise_pkg::OFS_PCLATCH, 32'h18);
    wr(cise_pkg::OFS_STATUS, 32'h2);
    xfer(1'b0, cise_pkg::OFS_CYCLES, 32'h0);
    c0 = r;
    ex(cise_pkg::OP_CALL, 1'b0, 11'h5a5);
    rc(cise_pkg::OFS_PC, 32'h1da5);
    rc(cise_pkg::OFS_TOS, 32'h0124);
    rc(cise_pkg::OFS_STKPTR, 32'h1);
    rc(cise_pkg::OFS_STATUS, 32'h2);
    rc(cise_pkg::OFS_CYCLES, c0 + 32'h2);
    rc(cise_pkg::OFS_PCLATCH, 32'h18);
    $display("call done");
    repeat (300) @(posedge pclk);
    xfer(1'b0, cise_pkg::OFS_WATCHDOG, 32'h0);
    chk({31'h0, |r[7:0]}, 32'h1);
    wr(cise_pkg::OFS_STATUS, 32'h1);
    ex(cise_pkg::OP_CLEAR_WATCHDOG, 1'b0, 11'h0);
    xfer(1'b0, cise_pkg::OFS_WATCHDOG, 32'h0);
    chk({24'h0, r[7:0]}, 32'h0);
    chk({31'h0, r[15:8] < 8'h10}, 32'h1);
    rc(cise_pkg::OFS_STATUS, 32'h7);
    $display("watchdog done");
    wr(cise_pkg::OFS_PC, 32'h20);
    ex(cise_pkg::OP_NOP, 1'b0, 11'h0);
    ex(4'h8, 1'b1, 11'h7ff);
    rc(cise_pkg::OFS_INSTR, 32'h8fff);
    rc(cise_pkg::OFS_PC, 32'h22);
    rc(cise_pkg::OFS_STATUS, 32'h7);
    xfer(1'b0, cise_pkg::OFS_CYCLES, 32'h0);
    c0 = r;
    wr(cise_pkg::OFS_CYCLES, 32'h0);
    chk({31'h0, e}, 32'h0);
    rc(cise_pkg::OFS_CYCLES, c0);
    $display("nop and read-only done");
    rc(8'h40, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(cise_pkg::OFS_WREG, 32'h3c);
    chk({31'h0, e}, 32'h0);
    wr(8'h05, 32'hff);
    chk({31'h0, e}, 32'h1);
    rc(cise_pkg::OFS_WREG, 32'h3c);
    $display("unmapped done");
    print_verdict;
  end
endmodule
